// ==== rtl/vco_modulator_cfg.sv ====
`include "vco_cfg_map.svh"

module vco_modulator_cfg (
   input wire logic clk, // 50 MHz digital clock
   input wire logic rst_n, // async reset, active low
   input wire logic reg_wr, // one-cycle write strobe from serial port
   input wire logic reg_rd, // one-cycle read strobe from serial port
   input wire logic [5:0] reg_addr, // register address
   input wire logic [23:0] reg_wdata, // write data
   output logic [23:0] rd_data, // read data, valid with rd_valid
   output logic rd_valid, // one-cycle read answer
   input wire logic cal_data_wr, // calibration engine data update pulse
   input wire logic [8:0] cal_data, // calibration data field
   input wire logic int_wr, // integer frequency register written
   input wire logic frac_wr, // fractional frequency register written
   input wire logic ref_tick, // reference divider tick for self test
   output logic vco_sclk, // serial clock to oscillator subsystem
   output logic vco_sdata, // serial data to oscillator subsystem
   output logic vco_sen, // frame enable to oscillator subsystem
   output logic vco_done, // pulse after each forwarded word
   output logic [23:0] mod_seed, // active modulator seed
   output logic seed_load, // pulse: modulator loads mod_seed
   output logic [1:0] mod_order, // modulator type
   output logic mod_bypass, // modulator output ignored
   output logic mod_use_vco_clk, // 1 oscillator divider clock, 0 reference clock
   output logic frac_core_en, // fractional core enable
   output logic cal_start, // pulse: start oscillator calibration
   output logic test_busy, // self test running
   output logic test_done // self test finished
);
   vco_cfg_pkg::cfg_regs_t r, n;
   logic [15:0] fwd_last;

   function automatic logic [23:0] seed_value(input logic [1:0] code);
      case (code)
         2'h0: seed_value = `SEED_CODE0;
         2'h1: seed_value = `SEED_CODE1;
         2'h2: seed_value = `SEED_CODE2;
         default: seed_value = `SEED_CODE3;
      endcase
   endfunction

   vco_forwarder u_fwd (
      .clk(clk),
      .rst_n(rst_n),
      .req_valid(r.fwd_req),
      .req_word(r.fwd_word),
      .sclk(vco_sclk),
      .sdata(vco_sdata),
      .sen(vco_sen),
      .done(vco_done),
      .last_word(fwd_last)
   );

   self_test_timer u_test (
      .clk(clk),
      .rst_n(rst_n),
      .enable(r.mcfg[`MCFG_TESTEN_BIT]),
      .length(r.mcfg[`MCFG_TESTLEN_LSB +: 2]),
      .ref_tick(ref_tick),
      .busy(test_busy),
      .done(test_done)
   );

   assign rd_data = r.rd_data;
   assign rd_valid = r.rd_valid;
   assign mod_seed = r.seed;
   assign seed_load = r.seed_load;
   assign mod_order = r.mcfg[`MCFG_ORDER_LSB +: 2];
   assign mod_bypass = r.mcfg[`MCFG_BYPASS_BIT];
   assign frac_core_en = r.mcfg[`MCFG_FRACEN_BIT];
   assign mod_use_vco_clk = r.use_vco_clk;
   assign cal_start = r.cal_start;

   always_comb begin
      n = r;
      n.seed_load = 1'b0;
      n.fwd_req = 1'b0;
      n.rd_valid = 1'b0;
      if (reg_wr && reg_addr == `VIND_OFFSET) begin
         n.vind = reg_wdata[15:0];
         n.fwd_req = 1'b1;
         n.fwd_word = reg_wdata[15:0];
      end else if (cal_data_wr) begin
         // calibration only rewrites data; identifier and address come from the host image
         n.vind[`VIND_DATA_LSB +: `VIND_DATA_W] = cal_data;
         n.fwd_req = 1'b1;
         n.fwd_word = {cal_data, r.vind[`VIND_DATA_LSB-1:0]};
      end
      if (reg_wr && reg_addr == `MCFG_OFFSET) begin
         // the seed code only lands here; the running seed is untouched
         n.mcfg = reg_wdata[22:0];
      end
      if (frac_wr && r.mcfg[`MCFG_RESEED_BIT]) begin
         n.seed = seed_value(r.mcfg[`MCFG_SEED_LSB +: 2]);
         n.seed_load = 1'b1;
      end
      n.cal_start = r.mcfg[`MCFG_FRACEN_BIT] ? frac_wr : int_wr;
      if (r.mcfg[`MCFG_CLKOVR_BIT] || r.mcfg[`MCFG_AUTOCLK_BIT]) begin
         n.use_vco_clk = 1'b1;
      end else begin
         n.use_vco_clk = r.mcfg[`MCFG_CLKSRC_BIT];
      end
      if (reg_rd) begin
         n.rd_valid = 1'b1;
         case (reg_addr)
            `VIND_OFFSET: n.rd_data = {8'h00, fwd_last};
            `MCFG_OFFSET: n.rd_data = {1'b0, r.mcfg};
            default: n.rd_data = '0;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         r <= '{vind: `VIND_RESET, mcfg: `MCFG_RESET, seed: `SEED_CODE2,
                fwd_word: `VIND_RESET, use_vco_clk: 1'b1, default: '0};
      end else begin
         r <= n;
      end
   end

   chk_fwd_start: assert property (@(posedge clk) disable iff (!rst_n)
      reg_wr && reg_addr == `VIND_OFFSET |=> r.fwd_req && r.fwd_word == $past(reg_wdata[15:0]))
      else $error("indirect write not forwarded");
   chk_cal_keep_id: assert property (@(posedge clk) disable iff (!rst_n)
      cal_data_wr && !reg_wr |=> r.fwd_word[6:0] == $past(r.vind[6:0])
         && r.fwd_word[15:7] == $past(cal_data))
      else $error("calibration altered identifier or address");
   chk_read_last: assert property (@(posedge clk) disable iff (!rst_n)
      reg_rd && reg_addr == `VIND_OFFSET |=> r.rd_valid && r.rd_data == {8'h00, $past(fwd_last)})
      else $error("indirect read not last transfer");
   chk_seed_load: assert property (@(posedge clk) disable iff (!rst_n)
      frac_wr && r.mcfg[`MCFG_RESEED_BIT]
         |=> seed_load && mod_seed == seed_value($past(r.mcfg[1:0])))
      else $error("seed not loaded on reseed write");
   chk_seed_hold: assert property (@(posedge clk) disable iff (!rst_n)
      !(frac_wr && r.mcfg[`MCFG_RESEED_BIT]) |=> !seed_load && $stable(mod_seed))
      else $error("active seed changed without reseed");
   chk_cal_trigger: assert property (@(posedge clk) disable iff (!rst_n)
      (frac_core_en ? frac_wr : int_wr) |=> cal_start)
      else $error("calibration trigger source wrong");
   chk_clk_override: assert property (@(posedge clk) disable iff (!rst_n)
      r.mcfg[`MCFG_CLKOVR_BIT] || r.mcfg[`MCFG_AUTOCLK_BIT] |=> mod_use_vco_clk)
      else $error("clock source not overridden");
   chk_clk_select: assert property (@(posedge clk) disable iff (!rst_n)
      !r.mcfg[`MCFG_CLKOVR_BIT] && !r.mcfg[`MCFG_AUTOCLK_BIT]
         |=> mod_use_vco_clk == $past(r.mcfg[`MCFG_CLKSRC_BIT]))
      else $error("clock source bit not followed");
endmodule

// ==== rtl/vco_cfg_map.svh ====
// Operation
// - every host write of the indirect register queues a forwarding transfer; a later write replaces one still waiting
// - indirect word: identifier [2:0], address [6:3], data [15:7], reset zero
// - indirect register reads return only the most recently forwarded word
// - seed code 0 zero, 1 lsb, 2 B29D08h, 3 50F1CDh; default code 2
// - written seed stays pending until fractional frequency write with reseed set; integer writes never load it
// - order field: 0 first, 1 second, 2 mode B default, 3 mode A
// - bypass set ignores modulator output; modulator still clocked
// - reseed set reloads seed on fractional write; clear keeps previous state
// - clock source bit picks oscillator or reference clock, ignored if bit 10/21
// - fractional enable gates core and picks integer or fractional calibration trigger
// - self-test enable starts divider self test; clear leaves it idle
// - self-test length: 1032, 2047, 3071 or 4095 reference cycles
`ifndef VCO_CFG_MAP_SVH
`define VCO_CFG_MAP_SVH

`define VIND_OFFSET 6'h05
`define MCFG_OFFSET 6'h06
`define VIND_RESET 16'h0000
`define MCFG_RESET 23'h20_0b4a

`define VIND_ID_LSB 0
`define VIND_ADDR_LSB 3
`define VIND_DATA_LSB 7
`define VIND_DATA_W 9

`define MCFG_SEED_LSB 0
`define MCFG_ORDER_LSB 2
`define MCFG_BYPASS_BIT 7
`define MCFG_RESEED_BIT 8
`define MCFG_CLKSRC_BIT 9
`define MCFG_CLKOVR_BIT 10
`define MCFG_FRACEN_BIT 11
`define MCFG_TESTEN_BIT 18
`define MCFG_TESTLEN_LSB 19
`define MCFG_AUTOCLK_BIT 21

`define SEED_CODE0 24'h00_0000
`define SEED_CODE1 24'h00_0001
`define SEED_CODE2 24'hb2_9d08
`define SEED_CODE3 24'h50_f1cd

`define TEST_LEN0 12'h0408
`define TEST_LEN1 12'h07ff
`define TEST_LEN2 12'h0bff
`define TEST_LEN3 12'h0fff

`define FWD_HALF_BIT 4'h4
`define FWD_WORD_BITS 4'hf

`endif

// ==== rtl/vco_cfg_pkg.sv ====
package vco_cfg_pkg;

   typedef enum logic [2:0] {
      FWD_IDLE = 3'h1,
      FWD_SHIFT = 3'h2,
      FWD_GAP = 3'h4
   } fwd_state_t;

   typedef enum logic [2:0] {
      TEST_IDLE = 3'h1,
      TEST_RUN = 3'h2,
      TEST_DONE = 3'h4
   } test_state_t;

   typedef struct packed {
      fwd_state_t st;
      logic pend_valid;
      logic [15:0] pend_word;
      logic [15:0] shreg;
      logic [3:0] bitcnt;
      logic [3:0] divcnt;
      logic sclk;
      logic sen;
      logic sdata;
      logic [15:0] last_word;
      logic done;
   } fwd_regs_t;

   typedef struct packed {
      test_state_t st;
      logic en_q;
      logic [11:0] cnt;
      logic [11:0] target;
      logic busy;
      logic done;
   } test_regs_t;

   typedef struct packed {
      logic [15:0] vind;
      logic [22:0] mcfg;
      logic [23:0] seed;
      logic seed_load;
      logic fwd_req;
      logic [15:0] fwd_word;
      logic [23:0] rd_data;
      logic rd_valid;
      logic cal_start;
      logic use_vco_clk;
   } cfg_regs_t;

endpackage

// ==== rtl/vco_forwarder.sv ====
`include "vco_cfg_map.svh"

module vco_forwarder #(
   parameter logic [3:0] HALF_BIT = `FWD_HALF_BIT
) (
   input wire logic clk, // system clock
   input wire logic rst_n, // async reset, active low
   input wire logic req_valid, // one-cycle request to forward req_word
   input wire logic [15:0] req_word, // word to forward
   output logic sclk, // serial clock to oscillator subsystem
   output logic sdata, // serial data, msb first
   output logic sen, // frame enable, high for a whole word
   output logic done, // one-cycle pulse after a word is sent
   output logic [15:0] last_word // word of the most recent transfer
);
   vco_cfg_pkg::fwd_regs_t r, n;

   assign sclk = r.sclk;
   assign sdata = r.sdata;
   assign sen = r.sen;
   assign done = r.done;
   assign last_word = r.last_word;

   always_comb begin
      n = r;
      n.done = 1'b0;
      case (r.st)
         vco_cfg_pkg::FWD_IDLE: begin
            if (r.pend_valid) begin
               n.shreg = r.pend_word;
               n.sdata = r.pend_word[15];
               n.last_word = r.pend_word;
               n.pend_valid = 1'b0;
               n.sen = 1'b1;
               n.sclk = 1'b0;
               n.bitcnt = '0;
               n.divcnt = '0;
               n.st = vco_cfg_pkg::FWD_SHIFT;
            end
         end
         vco_cfg_pkg::FWD_SHIFT: begin
            n.divcnt = r.divcnt + 4'h1;
            if (r.divcnt == HALF_BIT - 4'h1) begin
               n.divcnt = '0;
               n.sclk = ~r.sclk;
               if (r.sclk) begin
                  n.bitcnt = r.bitcnt + 4'h1;
                  if (r.bitcnt == `FWD_WORD_BITS) begin
                     n.sen = 1'b0;
                     n.st = vco_cfg_pkg::FWD_GAP;
                  end else begin
                     n.shreg = {r.shreg[14:0], 1'b0};
                     n.sdata = r.shreg[14];
                  end
               end
            end
         end
         vco_cfg_pkg::FWD_GAP: begin
            n.done = 1'b1;
            n.sdata = 1'b0;
            n.st = vco_cfg_pkg::FWD_IDLE;
         end
         default: n.st = vco_cfg_pkg::FWD_IDLE;
      endcase
      // one-deep queue: a later write replaces a waiting one, never the word on the wire
      if (req_valid) begin
         n.pend_valid = 1'b1;
         n.pend_word = req_word;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         r <= '{st: vco_cfg_pkg::FWD_IDLE, pend_word: `VIND_RESET,
                shreg: `VIND_RESET, last_word: `VIND_RESET, default: '0};
      end else begin
         r <= n;
      end
   end

   chk_frame_length: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(r.sen) |-> ##127 r.sen ##1 !r.sen)
      else $error("frame not held for sixteen bits");
   chk_done_after: assert property (@(posedge clk) disable iff (!rst_n)
      $fell(r.sen) |=> r.done)
      else $error("done pulse missing after frame");
   chk_queue_busy: assert property (@(posedge clk) disable iff (!rst_n)
      (r.st != vco_cfg_pkg::FWD_IDLE) && req_valid |=> r.pend_valid && $stable(r.last_word))
      else $error("write during transfer not queued");
endmodule

// ==== rtl/self_test_timer.sv ====
`include "vco_cfg_map.svh"

module self_test_timer (
   input wire logic clk, // system clock
   input wire logic rst_n, // async reset, active low
   input wire logic enable, // self-test enable level
   input wire logic [1:0] length, // test length code
   input wire logic ref_tick, // one-cycle reference divider tick
   output logic busy, // test running
   output logic done // test finished, held until enable clears
);
   vco_cfg_pkg::test_regs_t r, n;

   assign busy = r.busy;
   assign done = r.done;

   function automatic logic [11:0] len_count(input logic [1:0] code);
      case (code)
         2'h0: len_count = `TEST_LEN0;
         2'h1: len_count = `TEST_LEN1;
         2'h2: len_count = `TEST_LEN2;
         default: len_count = `TEST_LEN3;
      endcase
   endfunction

   always_comb begin
      n = r;
      n.en_q = enable;
      case (r.st)
         vco_cfg_pkg::TEST_IDLE: begin
            if (enable && !r.en_q) begin
               n.cnt = '0;
               n.target = len_count(length);
               n.st = vco_cfg_pkg::TEST_RUN;
            end
         end
         vco_cfg_pkg::TEST_RUN: begin
            if (ref_tick) begin
               n.cnt = r.cnt + 12'h001;
               if (r.cnt == r.target - 12'h001) begin
                  n.st = vco_cfg_pkg::TEST_DONE;
               end
            end
         end
         vco_cfg_pkg::TEST_DONE: n.st = r.st;
         default: n.st = vco_cfg_pkg::TEST_IDLE;
      endcase
      if (!enable) begin
         n.st = vco_cfg_pkg::TEST_IDLE;
      end
      n.busy = (n.st == vco_cfg_pkg::TEST_RUN);
      n.done = (n.st == vco_cfg_pkg::TEST_DONE);
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         r <= '{st: vco_cfg_pkg::TEST_IDLE, default: '0};
      end else begin
         r <= n;
      end
   end

   chk_test_idle: assert property (@(posedge clk) disable iff (!rst_n)
      !enable |=> !r.busy && !r.done)
      else $error("self test active while disabled");
   chk_test_count: assert property (@(posedge clk) disable iff (!rst_n)
      r.busy && enable && ref_tick && (r.cnt == r.target - 12'h001) |=> r.done)
      else $error("self test did not end at length");
   chk_test_target: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(r.busy) |-> r.target == len_count($past(length)))
      else $error("self test length decode wrong");
endmodule

// ==== bench/vco_subsys_model.sv ====
module vco_subsys_model (
   input wire logic sclk, // serial clock from the forwarder
   input wire logic sdata, // serial data, msb first
   input wire logic sen, // frame enable
   output logic [15:0] rx_word, // last complete word
   output int rx_bits, // bits counted in the last frame
   output int frames // frames received so far
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] sh;
   int cnt;
   initial begin
      sh = 16'h0000;
      cnt = 0;
      rx_word = 16'h0000;
      rx_bits = 0;
      frames = 0;
   end
   // bits are taken on sclk rise inside the frame only
   always @(posedge sclk) begin
      if (sen === 1'b1) begin
         sh = {sh[14:0], sdata};
         cnt = cnt + 1;
      end
   end
   // a frame with no bits (sen settling out of reset) is not a transfer
   always @(negedge sen) begin
      if (cnt > 0) begin
         rx_word = sh;
         rx_bits = cnt;
         cnt = 0;
         frames = frames + 1;
      end
   end
endmodule

// ==== bench/vco_modulator_cfg_tb.sv ====
module vco_modulator_cfg_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, rst_n, reg_wr, reg_rd, cal_data_wr, int_wr, frac_wr, ref_tick;
   logic [5:0] reg_addr;
   logic [23:0] reg_wdata, rd_data, mod_seed;
   logic [8:0] cal_data;
   logic rd_valid, vco_sclk, vco_sdata, vco_sen, vco_done, seed_load, mod_bypass;
   logic mod_use_vco_clk, frac_core_en, cal_start, test_busy, test_done;
   logic [1:0] mod_order;
   logic [15:0] rx_word;
   int rx_bits, frames, miscompares, check_count;
   logic [23:0] seeds [4] = '{24'h00_0000, 24'h00_0001, 24'hb2_9d08, 24'h50_f1cd};
   int lens [4] = '{1032, 2047, 3071, 4095};
   // row: written word, then {order, bypass, enable, clock source} expected
   logic [23:0] row_w [4] = '{24'h00_0082, 24'h00_0a05, 24'h00_0c88, 24'ha0_000c};
   logic [4:0] row_x [4] = '{5'h04, 5'h0b, 5'h17, 5'h19};

   vco_modulator_cfg dut (.clk(clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .rd_data(rd_data), .rd_valid(rd_valid),
      .cal_data_wr(cal_data_wr), .cal_data(cal_data), .int_wr(int_wr), .frac_wr(frac_wr),
      .ref_tick(ref_tick), .vco_sclk(vco_sclk), .vco_sdata(vco_sdata), .vco_sen(vco_sen),
      .vco_done(vco_done), .mod_seed(mod_seed), .seed_load(seed_load),
      .mod_order(mod_order), .mod_bypass(mod_bypass), .mod_use_vco_clk(mod_use_vco_clk),
      .frac_core_en(frac_core_en), .cal_start(cal_start), .test_busy(test_busy),
      .test_done(test_done));

   vco_subsys_model sub (.sclk(vco_sclk), .sdata(vco_sdata), .sen(vco_sen),
      .rx_word(rx_word), .rx_bits(rx_bits), .frames(frames));

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   task automatic check(input logic [23:0] seen, input logic [23:0] exp);
      check_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wrap_up;
      if (miscompares == 0 && check_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic do_reset;
      rst_n = 1'b0;
      repeat (6) @(negedge clk);
      rst_n = 1'b1;
      @(negedge clk);
   endtask

   task automatic wr(input logic [5:0] a, input logic [23:0] d);
      @(negedge clk);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(negedge clk);
      reg_wr = 1'b0;
   endtask

   task automatic rd_chk(input logic [5:0] a, input logic [23:0] exp);
      @(negedge clk);
      reg_rd = 1'b1;
      reg_addr = a;
      @(negedge clk);
      // rd_valid stands for this one cycle only, so look before the next edge
      check(24'(rd_valid), 24'h00_0001);
      check(rd_data, exp);
      reg_rd = 1'b0;
   endtask

   // sel 0 fractional write, 1 integer write, 2 reference tick, 3 calibration update
   task automatic strobe(input int sel);
      @(negedge clk);
      frac_wr = (sel == 0);
      int_wr = (sel == 1);
      ref_tick = (sel == 2);
      cal_data_wr = (sel == 3);
      @(negedge clk);
      frac_wr = 1'b0;
      int_wr = 1'b0;
      ref_tick = 1'b0;
      cal_data_wr = 1'b0;
   endtask

   task automatic wait_frames(input int n);
      for (int i = 0; i < 400 && frames < n; i++) @(negedge clk);
   endtask

   task automatic check_cfg(input logic [4:0] x);
      check(24'(mod_order), 24'(x[4:3]));
      check(24'(mod_bypass), 24'(x[2]));
      check(24'(frac_core_en), 24'(x[1]));
      check(24'(mod_use_vco_clk), 24'(x[0]));
   endtask

   initial begin
      repeat (40000) @(posedge clk);
      miscompares++;
      wrap_up;
   end

   initial begin
      logic [23:0] seed_was;
      {rst_n, reg_wr, reg_rd, cal_data_wr, int_wr, frac_wr, ref_tick} = 7'h00;
      reg_addr = 6'h00;
      reg_wdata = 24'h00_0000;
      cal_data = 9'h000;
      miscompares = 0;
      check_count = 0;
      do_reset;
      check(mod_seed, 24'hb2_9d08);
      check_cfg(5'h13);
      check(24'(test_busy), 24'h00_0000);
      rd_chk(6'h06, 24'h20_0b4a);
      rd_chk(6'h05, 24'h00_0000);
      for (int i = 0; i < 4; i++) begin
         wr(6'h06, row_w[i]);
         repeat (2) @(negedge clk);
         check_cfg(row_x[i]);
         rd_chk(6'h06, row_w[i] & 24'h7f_ffff);
      end
      wr(6'h07, 24'h12_3456);
      rd_chk(6'h07, 24'h00_0000);
      for (int c = 0; c < 4; c++) begin
         seed_was = mod_seed;
         wr(6'h06, 24'h20_0b48 | 24'(c));
         repeat (2) @(negedge clk);
         check(mod_seed, seed_was);
         strobe(0);
         check(24'(seed_load), 24'h00_0001);
         check(mod_seed, seeds[c]);
         check(24'(cal_start), 24'h00_0001);
      end
      wr(6'h06, 24'h20_0a49);
      strobe(0);
      check(24'(seed_load), 24'h00_0000);
      check(mod_seed, seeds[3]);
      strobe(1);
      check(24'(cal_start), 24'h00_0000);
      wr(6'h06, 24'h20_0248);
      strobe(1);
      check(24'(cal_start), 24'h00_0001);
      strobe(0);
      check(24'(cal_start), 24'h00_0000);
      // second word lands while the first is still on the wire
      wr(6'h05, 24'h00_a5a3);
      wr(6'h05, 24'h00_3c80);
      wait_frames(1);
      // done follows one cycle after the frame enable drops
      check(24'(vco_done), 24'h00_0000);
      @(negedge clk);
      check(24'(vco_done), 24'h00_0001);
      check(24'(rx_word), 24'h00_a5a3);
      check(24'(rx_bits), 24'h00_0010);
      wait_frames(2);
      check(24'(rx_word), 24'h00_3c80);
      rd_chk(6'h05, 24'h00_3c80);
      cal_data = 9'h1a5;
      strobe(3);
      wait_frames(3);
      check(24'(rx_word), {8'h00, 9'h1a5, 7'h00});
      rd_chk(6'h05, {8'h00, 9'h1a5, 7'h00});
      for (int c = 0; c < 4; c++) begin
         wr(6'h06, 24'h20_0b4a | (24'(c) << 19) | 24'h04_0000);
         repeat (2) @(negedge clk);
         check(24'(test_busy), 24'h00_0001);
         for (int i = 0; i < lens[c] - 1; i++) strobe(2);
         @(negedge clk);
         check(24'(test_done), 24'h00_0000);
         strobe(2);
         @(negedge clk);
         check(24'(test_done), 24'h00_0001);
         check(24'(test_busy), 24'h00_0000);
         wr(6'h06, 24'h20_0b4a);
         repeat (2) @(negedge clk);
         check(24'(test_done), 24'h00_0000);
      end
      wr(6'h06, 24'h00_0081);
      do_reset;
      check(mod_seed, 24'hb2_9d08);
      rd_chk(6'h06, 24'h20_0b4a);
      wrap_up;
   end
endmodule
